/* File: dv/i2cmrx_monitor.sv */
`timescale 1ns/1ps
module i2cmrx_monitor
  import i2cmrx_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic [3:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  input logic scl_in,
  input logic scl_out,
  input logic scl_oe,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe,
  input logic master_interrupt
);
  // ----------------------------------------
  // Command tracking
  // ----------------------------------------
  logic [4:0] cmd_q;
  logic lvl_q;
  logic [11:0] cnt_q;
  logic [8:0] baud_q;
  wire ctl_w = reg_wr && reg_addr == ADDR_CONTROL;
  // The design is free again in the cycle its interrupt pulse stands
  wire go_w = ctl_w && (cmd_q == 5'h00 || master_interrupt) && reg_wdata[4:0] != 5'h00;
  wire baud_w = reg_wr && reg_addr == ADDR_BAUD;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_q <= 5'h00;
      lvl_q <= 1'b0;
      cnt_q <= 12'h000;
      baud_q <= BAUD_RESET;
    end
    else
    begin
      cmd_q <= go_w ? reg_wdata[4:0] : master_interrupt ? 5'h00 : cmd_q;
      lvl_q <= ctl_w ? reg_wdata[CTL_ACKLVL_BIT] : lvl_q;
      cnt_q <= go_w ? 12'h000 : cnt_q + 12'h001;
      baud_q <= baud_w ? reg_wdata[8:0] : baud_q;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_ack_end;
    sda_oe == !lvl_q ##1 !sda_oe;
  endsequence
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_txstat_clear: assert property (reg_rd && reg_addr == ADDR_STATUS |=> !reg_rdata[ST_TXSTAT])
    else $error("tx status set");
  a_ack_level: assert property (cmd_q[CTL_ACK_BIT] && !scl_oe |-> sda_oe == !lvl_q)
    else $error("ack level wrong");
  a_ack_end_order: assert property (cmd_q[CTL_ACK_BIT] && $rose(scl_oe) |-> s_ack_end)
    else $error("ack end order");
  // Sync delays on the wire give slack above the two periods
  a_ack_duration: assert property (cmd_q[CTL_ACK_BIT] && master_interrupt |->
    cnt_q >= 2 * baud_q && cnt_q <= 2 * baud_q + 24)
    else $error("ack length wrong");
  a_stop_order: assert property (cmd_q[CTL_STOP_BIT] && $fell(scl_oe) |-> sda_oe)
    else $error("stop order");
  a_rs_release: assert property (cmd_q[CTL_REPEATED_START_COMMAND_BIT_BIT] && $fell(scl_oe) |-> !sda_oe)
    else $error("rstart release");
  a_rs_data_low: assert property (cmd_q[CTL_REPEATED_START_COMMAND_BIT_BIT] && $rose(sda_oe) |-> !scl_oe)
    else $error("rstart data low");
  a_rx_stretch: assert property (cmd_q[CTL_RX_BIT] && !scl_oe && !scl_in |=> !scl_oe)
    else $error("stretch ignored");
endmodule

bind i2cmrx_top i2cmrx_monitor i_i2cmrx_monitor (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .master_interrupt(master_interrupt));

/* File: dv/i2cmrx_slave.sv */
`timescale 1ns/1ps
module i2cmrx_slave
(
  input logic clk,
  input logic scl,
  input logic go,
  input logic [7:0] tx_byte,
  input logic [3:0] stretch,
  output logic scl_hold,
  output logic sda_hold
);
  // ----------------------------------------
  // Byte sender, stretches before the first bit
  // ----------------------------------------
  initial
  begin
    scl_hold = 1'b0;
    sda_hold = 1'b0;
  end
  always
  begin
    wait (go);
    @(posedge clk);
    wait (!scl);
    scl_hold = 1'b1;
    repeat (stretch) @(posedge clk);
    #1 sda_hold = !tx_byte[7];
    scl_hold = 1'b0;
    for (int i = 6; i >= -1; i--)
    begin
      @(negedge scl);
      sda_hold = i >= 0 && !tx_byte[i];
    end
  end
endmodule

/* File: dv/i2cmrx_top_test.sv */
`timescale 1ns/1ps
module i2cmrx_top_test;
  import i2cmrx_pkg::*;
  localparam logic [15:0] F_FULL = 16'h0001 << ST_FULL;
  localparam logic [15:0] F_OVF = 16'h0001 << ST_OVF;
  localparam logic [15:0] F_WCOL = 16'h0001 << ST_WCOL;
  localparam logic [15:0] F_TX = 16'h0001 << ST_TXSTAT;
  localparam logic [15:0] F_S = 16'h0001 << ST_START;
  localparam logic [15:0] F_P = 16'h0001 << ST_STOP;
  logic clk, arst_n, reg_wr, reg_rd, scl_oe, sda_oe, irq, s_scl, s_sda, go, ack_oe;
  logic [3:0] reg_addr, stretch;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] sbyte;
  int mismatches, check_count;
  // Pull-ups: a released line reads high
  wire scl = !(scl_oe | s_scl);
  wire sda = !(sda_oe | s_sda);
  i2cmrx_top i_i2cmrx_top (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .master_interrupt(irq));
  i2cmrx_slave i_i2cmrx_slave (.clk(clk), .scl(scl), .go(go), .tx_byte(sbyte),
    .stretch(stretch), .scl_hold(s_scl), .sda_hold(s_sda));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
    @(posedge clk);
  endtask
  task automatic rx(input logic [7:0] b, input logic [3:0] s);
    sbyte <= b;
    stretch <= s;
    go <= 1'b1;
    wr(ADDR_CONTROL, 16'h0008);
    go <= 1'b0;
  endtask
  // Keeps the data drive enable last seen while the clock was released
  task automatic wait_irq;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
      if (scl_oe === 1'b0)
        ack_oe = sda_oe;
    end
    while (irq !== 1'b1 && n < 3000);
    if (irq !== 1'b1)
    begin
      mismatches++;
      $display("Error at %0t: interrupt got %h expected %h", $time, irq, 1'b1);
      give_verdict();
    end
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    arst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, go, sbyte, stretch, ack_oe} = '0;
    mismatches = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_BAUD, 16'h01ff, 16'h0004);
    wr(ADDR_BAUD, 16'h0005);
    wr(ADDR_TRANSMIT, 16'h0011);
    rx(8'ha5, 4'hc);
    wr(ADDR_TRANSMIT, 16'h0077);
    wr(ADDR_CONTROL, 16'h0010);
    wait_irq();
    rd(ADDR_CONTROL, 16'h003f, 16'h0000);
    rd(ADDR_STATUS, F_FULL | F_WCOL | F_TX, F_FULL | F_WCOL);
    rd(ADDR_TRANSMIT, 16'hffff, 16'h0011);
    rx(8'h3c, 4'h0);
    wait_irq();
    rd(ADDR_STATUS, F_FULL | F_OVF, F_FULL | F_OVF);
    rd(ADDR_RECEIVE, 16'hffff, 16'h00a5);
    rd(ADDR_STATUS, F_FULL, 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      rx(k ? 8'h5a : 8'h96, 4'h2);
      wait_irq();
      rd(ADDR_RECEIVE, 16'hffff, k ? 16'h005a : 16'h0096);
      wr(ADDR_CONTROL, k ? 16'h0030 : 16'h0010);
      wait_irq();
      chk({15'h0000, ack_oe}, {15'h0000, k == 0});
    end
    wr(ADDR_CONTROL, 16'h0004);
    wait_irq();
    rd(ADDR_STATUS, F_S | F_P, F_P);
    wr(ADDR_CONTROL, 16'h0002);
    wait_irq();
    rd(ADDR_STATUS, F_S | F_P, F_S);
    rd(ADDR_CONTROL, 16'h001f, 16'h0000);
    rd(4'hf, 16'hffff, 16'h0000);
    give_verdict();
  end
endmodule

/* File: hw/i2cmrx_pkg.sv */
package i2cmrx_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_BAUD = 4'h2;
  localparam logic [3:0] ADDR_TRANSMIT = 4'h3;
  localparam logic [3:0] ADDR_RECEIVE = 4'h4;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_SEN = 0;
  localparam int CTL_REPEATED_START_COMMAND_BIT_BIT = 1;
  localparam int CTL_STOP_BIT = 2;
  localparam int CTL_RX_BIT = 3;
  localparam int CTL_ACK_BIT = 4;
  localparam int CTL_ACKLVL_BIT = 5;
  localparam int ST_FULL = 1;
  localparam int ST_START = 3;
  localparam int ST_STOP = 4;
  localparam int ST_OVF = 6;
  localparam int ST_WCOL = 7;
  localparam int ST_TXSTAT = 14;
  localparam int BAUD_W = 9;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 9'h004;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0000,
    ST_RX_LOW = 4'b0001,
    ST_RX_REL = 4'b0010,
    ST_RX_HIGH = 4'b0011,
    ST_ACK_LOW = 4'b0100,
    ST_ACK_HIGH = 4'b0101,
    ST_P_LOW = 4'b0110,
    ST_P_SCL = 4'b0111,
    ST_P_SDA = 4'b1000,
    ST_RS_LOW = 4'b1001,
    ST_RS_REL = 4'b1010,
    ST_RS_HIGH = 4'b1011,
    ST_RS_SDA = 4'b1100
  } i2cmrx_state_t;
endpackage

/* File: hw/i2cmrx_top.sv */
`timescale 1ns/1ps
// Contract
// - Receive command clocks in and samples bits
// - Eighth bit: clear, buffer, full, interrupt
// - Transmit status stays clear while receiving
// - Buffer read clears full flag
// - Byte while full sets overflow, discarded
// - Overflow does not block later reception
// - Transmit write while busy sets collision
// - Command bit writes ignored while busy
// - Acknowledge command sends selected level
// - Acknowledge lasts two periods, then interrupt
// - Ack data driven once clock low
// - Ack end: clock low, then release data
// - Stop: data low, clock, data, done
// - Stop seen sets stop flag, clears start
// - Repeated start: clock low, release data
// - Repeated start high, data low, finish
// - Start seen sets start flag, clears stop
// - Reception honours slave clock stretching
// - Counter reloads nine-bit baud field
module i2cmrx_top
  import i2cmrx_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic master_interrupt
);
  import i2cmrx_pkg::*;

  // ----------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic sda_prev_q;
  logic scl_prev_q;
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      sda_prev_q <= sda_sync_q[1];
      scl_prev_q <= scl_sync_q[1];
    end
  end
  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  // Bus conditions seen on the wire, whoever made them
  wire stop_seen = scl_s && scl_prev_q && sda_s && !sda_prev_q;
  wire start_seen = scl_s && scl_prev_q && !sda_s && sda_prev_q;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  i2cmrx_state_t state_q;
  i2cmrx_state_t state_d;
  logic [4:0] cmd_q;
  logic [4:0] cmd_d;
  logic ack_level_q;
  logic [BAUD_W-1:0] baud_reload_value_q;
  logic [BAUD_W-1:0] baud_cnt_q;
  logic [BAUD_W-1:0] baud_cnt_d;
  logic [7:0] receive_shift_register_q;
  logic [7:0] shift_d;
  logic [7:0] receive_buffer_q;
  logic [7:0] transmit_buffer_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic receive_full_flag_q;
  logic receive_overflow_flag_q;
  logic write_collision_flag_q;
  logic start_flag_q;
  logic stop_flag_q;
  logic scl_low_q;
  logic scl_low_d;
  logic sda_low_q;
  logic sda_low_d;
  logic irq_q;
  logic done_d;
  logic byte_done_d;

  wire busy = (state_q != ST_IDLE) || (cmd_q != 5'h00);
  wire baud_zero = (baud_cnt_q == '0);
  wire wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
  wire wr_tx = reg_wr && (reg_addr == ADDR_TRANSMIT);
  wire rd_rx = reg_rd && (reg_addr == ADDR_RECEIVE);
  wire [BAUD_W-1:0] baud_dec = baud_cnt_q - 9'h001;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cmd_d = cmd_q;
    baud_cnt_d = baud_zero ? baud_cnt_q : baud_dec;
    bit_cnt_d = bit_cnt_q;
    shift_d = receive_shift_register_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    done_d = 1'b0;
    byte_done_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        baud_cnt_d = baud_reload_value_q;
        if (cmd_q[CTL_RX_BIT])
        begin
          state_d = ST_RX_LOW;
          bit_cnt_d = 4'h0;
          scl_low_d = 1'b1;
          sda_low_d = 1'b0;
        end
        else if (cmd_q[CTL_ACK_BIT])
        begin
          state_d = ST_ACK_LOW;
          scl_low_d = 1'b1;
        end
        else if (cmd_q[CTL_STOP_BIT])
        begin
          state_d = ST_P_LOW;
          sda_low_d = 1'b1;
        end
        else if (cmd_q[CTL_REPEATED_START_COMMAND_BIT_BIT])
        begin
          state_d = ST_RS_LOW;
          scl_low_d = 1'b1;
        end
      end
      ST_RX_LOW:
        if (baud_zero)
        begin
          scl_low_d = 1'b0;
          state_d = ST_RX_REL;
        end
      ST_RX_REL:
      begin
        // Counter is held until the slave lets the clock rise
        baud_cnt_d = baud_reload_value_q;
        if (scl_s)
          state_d = ST_RX_HIGH;
      end
      ST_RX_HIGH:
        if (baud_zero)
        begin
          shift_d = {receive_shift_register_q[6:0], sda_s};
          scl_low_d = 1'b1;
          baud_cnt_d = baud_reload_value_q;
          bit_cnt_d = bit_cnt_q + 4'h1;
          if (bit_cnt_q == BITS_PER_BYTE - 4'h1)
          begin
            state_d = ST_IDLE;
            cmd_d[CTL_RX_BIT] = 1'b0;
            byte_done_d = 1'b1;
            done_d = 1'b1;
          end
          else
            state_d = ST_RX_LOW;
        end
      ST_ACK_LOW:
        if (!scl_s)
        begin
          sda_low_d = !ack_level_q;
          if (baud_zero)
          begin
            scl_low_d = 1'b0;
            baud_cnt_d = baud_reload_value_q;
            state_d = ST_ACK_HIGH;
          end
        end
        else
          baud_cnt_d = baud_reload_value_q;
      ST_ACK_HIGH:
        if (baud_zero)
        begin
          // Data is released in the cycle after the clock falls
          scl_low_d = 1'b1;
          state_d = ST_IDLE;
          cmd_d[CTL_ACK_BIT] = 1'b0;
          done_d = 1'b1;
        end
      ST_P_LOW:
        if (baud_zero)
        begin
          scl_low_d = 1'b0;
          baud_cnt_d = baud_reload_value_q;
          state_d = ST_P_SCL;
        end
      ST_P_SCL:
        if (baud_zero)
        begin
          sda_low_d = 1'b0;
          baud_cnt_d = baud_reload_value_q;
          state_d = ST_P_SDA;
        end
      ST_P_SDA:
        if (baud_zero)
        begin
          state_d = ST_IDLE;
          cmd_d[CTL_STOP_BIT] = 1'b0;
          done_d = 1'b1;
        end
      ST_RS_LOW:
        if (scl_s)
          baud_cnt_d = baud_reload_value_q;
        else
        begin
          sda_low_d = 1'b0;
          if (baud_zero && sda_s)
          begin
            scl_low_d = 1'b0;
            state_d = ST_RS_REL;
          end
        end
      ST_RS_REL:
      begin
        baud_cnt_d = baud_reload_value_q;
        if (scl_s)
          state_d = ST_RS_HIGH;
      end
      ST_RS_HIGH:
        if (baud_zero)
        begin
          sda_low_d = 1'b1;
          baud_cnt_d = baud_reload_value_q;
          state_d = ST_RS_SDA;
        end
      ST_RS_SDA:
        if (baud_zero)
        begin
          scl_low_d = 1'b1;
          state_d = ST_IDLE;
          cmd_d[CTL_REPEATED_START_COMMAND_BIT_BIT] = 1'b0;
          done_d = 1'b1;
        end
      default:
        state_d = ST_IDLE;
    endcase
    if (wr_ctl && !busy)
      cmd_d = reg_wdata[4:0];
  end

  // Ack release follows the clock fall by one cycle
  wire ack_release = (state_q == ST_IDLE) && scl_low_q && sda_low_q && !cmd_q[CTL_STOP_BIT];

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_IDLE;
      cmd_q <= 5'h00;
      baud_cnt_q <= BAUD_RESET;
      bit_cnt_q <= 4'h0;
      receive_shift_register_q <= 8'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      baud_cnt_q <= baud_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      receive_shift_register_q <= shift_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= ack_release ? 1'b0 : sda_low_d;
      irq_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Software registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ack_level_q <= 1'b0;
      baud_reload_value_q <= BAUD_RESET;
      receive_buffer_q <= 8'h00;
      transmit_buffer_q <= 8'hff;
      receive_full_flag_q <= 1'b0;
      receive_overflow_flag_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      start_flag_q <= 1'b0;
      stop_flag_q <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        ack_level_q <= reg_wdata[CTL_ACKLVL_BIT];
      if (reg_wr && reg_addr == ADDR_BAUD)
        baud_reload_value_q <= reg_wdata[BAUD_W-1:0];
      if (wr_tx && !busy)
        transmit_buffer_q <= reg_wdata[7:0];
      // Hardware set wins over software clear on every flag
      if (wr_tx && busy)
        write_collision_flag_q <= 1'b1;
      else if (reg_wr && reg_addr == ADDR_STATUS && !reg_wdata[ST_WCOL])
        write_collision_flag_q <= 1'b0;
      if (byte_done_d && receive_full_flag_q && !rd_rx)
        receive_overflow_flag_q <= 1'b1;
      else if (reg_wr && reg_addr == ADDR_STATUS && !reg_wdata[ST_OVF])
        receive_overflow_flag_q <= 1'b0;
      if (byte_done_d && (!receive_full_flag_q || rd_rx))
      begin
        receive_buffer_q <= shift_d;
        receive_full_flag_q <= 1'b1;
      end
      else if (rd_rx)
        receive_full_flag_q <= 1'b0;
      if (stop_seen)
      begin
        stop_flag_q <= 1'b1;
        start_flag_q <= 1'b0;
      end
      else if (start_seen)
      begin
        start_flag_q <= 1'b1;
        stop_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  always_comb
  begin
    status_word = 16'h0000;
    status_word[ST_FULL] = receive_full_flag_q;
    status_word[ST_START] = start_flag_q;
    status_word[ST_STOP] = stop_flag_q;
    status_word[ST_OVF] = receive_overflow_flag_q;
    status_word[ST_WCOL] = write_collision_flag_q;
    status_word[ST_TXSTAT] = 1'b0;
  end
  wire [15:0] rd_mux =
    (reg_addr == ADDR_CONTROL) ? {10'h000, ack_level_q, cmd_q} :
    (reg_addr == ADDR_STATUS) ? status_word :
    (reg_addr == ADDR_BAUD) ? {7'h00, baud_reload_value_q} :
    (reg_addr == ADDR_TRANSMIT) ? {8'h00, transmit_buffer_q} :
    (reg_addr == ADDR_RECEIVE) ? {8'h00, receive_buffer_q} : 16'h0000;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // Open drain: drive low or release only
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
  assign master_interrupt = irq_q;
endmodule
